/* core/dual_timer_consts.vh */
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH
// ==========================================================
// register byte offsets on the wishbone bus
`define OFS_MODE       8'h00
`define OFS_CTRL       8'h04
`define OFS_CNT0_LO    8'h08
`define OFS_CNT0_HI    8'h0c
`define OFS_CNT1_LO    8'h10
`define OFS_CNT1_HI    8'h14
`define OFS_PORT_CFG   8'h18
`define OFS_IRQ_STAT   8'h1c
`define OFS_IRQ_CLR    8'h20
`define OFS_IRQ_EN     8'h24
// ==========================================================
// timer_mode_reg field positions
`define B_GATE1        7
`define B_CT1          6
`define B_MODE1_HI     5
`define B_MODE1_LO     4
`define B_GATE0        3
`define B_CT0          2
`define B_MODE0_HI     1
`define B_MODE0_LO     0
// ==========================================================
// timer_control_reg field positions
`define B_FLAG1        7
`define B_RUN1         6
`define B_FLAG0        5
`define B_RUN0         4
// ==========================================================
// port_cfg_reg and interrupt register field positions
`define B_TOG0         0
`define B_TOG1         1
`define B_EV0          0
`define B_EV1          1
// ==========================================================
// operating modes
`define MODE_13        2'h0
`define MODE_16        2'h1
`define MODE_RELOAD    2'h2
`define MODE_SPLIT     2'h3
// ==========================================================
// timing and reset values
`define MC_CLOCKS      6
`define MC_LAST        3'h5
`define RST_BYTE       8'h00
`define RST_IRQ        2'h0
`define RST_TOGGLE     1'b1
`define PRESCALE_BITS  5
`endif

/* core/dual_timer_counter.v */
// How it works
// [R1] timer function counts one step per machine cycle of six clocks.
// [R2] counter function samples count pin each machine cycle, counts high-then-low.
// [R3] counted edge shows in the counter one machine cycle after detection.
// [R4] edge recognition spans two machine cycles, so at most clock over twelve.
// [R5] outside source holds each count pin level one machine cycle at least.
// [R6] per timer a function bit picks timing or counting; two bits pick mode.
// [R7] mode 0 is 13 bits: high byte plus low five bits of low byte.
// [R8] rollover from all ones to zeros sets that timer's overflow flag.
// [R9] count only when run bit set and gate clear or gate pin high.
// [R10] setting the run bit leaves the count bytes untouched.
// [R11] mode register holds gate bits: bit 7 timer one, bit 3 timer zero.
// [R12] mode 1 is the same but uses all sixteen bits.
// [R13] mode 2 counts low byte and reloads it from high byte on overflow.
// [R14] timer one in mode 3 stops, same as clearing its run bit.
// [R15] timer zero mode 3: two 8-bit counters, high byte borrows timer one controls.
// [R16] then timer one runs outside its mode 3; overflows still serve as baud.
// [R17] toggle enable makes each overflow invert the timer's count pin output.
// [R18] with toggle enabled the pin drives one until the first overflow.
// [R19] overflow flag stays until software writes zero or interrupt is acknowledged.
//
// Local design decisions: the Wishbone register port and the address map.
`include "dual_timer_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module dual_timer_counter (
  input  wire        CLK_IN,         // cpu clock, 50 mhz
  input  wire        SYS_RST_IN,     // async reset, active high
  input  wire        WB_CYC_IN,      // wishbone cycle
  input  wire        WB_STB_IN,      // wishbone strobe
  input  wire        WB_WE_IN,       // wishbone write enable
  input  wire [7:0]  WB_ADR_IN,      // byte address
  input  wire [3:0]  WB_SEL_IN,      // byte lane selects
  input  wire [31:0] WB_DAT_IN,      // write data
  output reg  [31:0] WB_DAT_OUT,     // read data
  output reg         WB_ACK_OUT,     // cycle acknowledge
  input  wire        COUNT0_IN,      // count_pin_zero level
  output wire        COUNT0_OUT,     // count_pin_zero toggle level
  output wire        COUNT0_OE_OUT,  // count_pin_zero drive enable
  input  wire        COUNT1_IN,      // count_pin_one level
  output wire        COUNT1_OUT,     // count_pin_one toggle level
  output wire        COUNT1_OE_OUT,  // count_pin_one drive enable
  input  wire        GATE0_PIN_IN,   // gate_input_pin for timer zero
  input  wire        GATE1_PIN_IN,   // gate_input_pin for timer one
  input  wire        INT_ACK0_IN,    // cpu took timer zero interrupt
  input  wire        INT_ACK1_IN,    // cpu took timer one interrupt
  output reg  [1:0]  OVF_FLAG_OUT,   // overflow flags one and zero
  output reg         BAUD_TICK_OUT,  // timer one overflow pulse
  output wire        IRQ_OUT         // level interrupt
);

  // ==========================================================
  // registers
  reg  [7:0] timer_mode_reg;
  reg  [7:0] timer_control_reg;
  reg  [7:0] port_cfg_reg;
  reg  [7:0] count_low_byte_zero;
  reg  [7:0] count_high_byte_zero;
  reg  [7:0] count_low_byte_one;
  reg  [7:0] count_high_byte_one;
  reg  [1:0] irq_status;
  reg  [1:0] irq_enable;
  reg  [1:0] toggle_level;

  // ==========================================================
  // synchronisers, machine cycle divider and edge detectors
  reg  [3:0] pin_meta;
  reg  [3:0] pin_sync;
  reg  [2:0] phase;
  reg  [1:0] sample;
  reg  [1:0] edge_pend;
  wire       mc_tick;
  wire [1:0] count_step;

  // ==========================================================
  // decoded control fields
  wire [1:0] mode_zero;
  wire [1:0] mode_one;
  wire       gate_zero;
  wire       gate_one;
  wire       func_zero;
  wire       func_one;
  wire       run_bit_zero;
  wire       run_bit_one;
  wire       overflow_flag_zero;
  wire       overflow_flag_one;
  wire       toggle_en_zero;
  wire       toggle_en_one;
  wire       split_zero;

  // ==========================================================
  // next values
  reg  [7:0] next_low_zero;
  reg  [7:0] next_high_zero;
  reg  [7:0] next_low_one;
  reg  [7:0] next_high_one;
  reg        ovf_zero;
  reg        ovf_zero_high;
  reg        ovf_one;
  reg        en_zero;
  reg        en_one;
  reg  [8:0] sum_high;
  reg  [7:0] rd_data;

  wire       bus_req;
  wire       wr_fire;
  wire [7:0] wdat;
  wire       set_flag_zero;
  wire       set_flag_one;
  wire [1:0] irq_clear;

  // ==========================================================
  // field decode
  assign mode_zero = {timer_mode_reg[`B_MODE0_HI],
                      timer_mode_reg[`B_MODE0_LO]};             // [R6]
  assign mode_one  = {timer_mode_reg[`B_MODE1_HI],
                      timer_mode_reg[`B_MODE1_LO]};             // [R6]
  assign gate_zero = timer_mode_reg[`B_GATE0];                  // [R11]
  assign gate_one  = timer_mode_reg[`B_GATE1];                  // [R11]
  assign func_zero = timer_mode_reg[`B_CT0];                    // [R6]
  assign func_one  = timer_mode_reg[`B_CT1];                    // [R6]
  assign run_bit_zero       = timer_control_reg[`B_RUN0];
  assign run_bit_one        = timer_control_reg[`B_RUN1];
  assign overflow_flag_zero = timer_control_reg[`B_FLAG0];
  assign overflow_flag_one  = timer_control_reg[`B_FLAG1];
  assign toggle_en_zero     = port_cfg_reg[`B_TOG0];
  assign toggle_en_one      = port_cfg_reg[`B_TOG1];
  assign split_zero         = (mode_zero == `MODE_SPLIT);

  // ==========================================================
  // one increment for modes 0, 1, 2 and the split low byte
  // returns {overflow, high byte, low byte}
  function [16:0] bump;
    input [1:0] m;
    input [7:0] lo;
    input [7:0] hi;
    reg   [13:0] s13;
    reg   [16:0] s16;
    reg   [8:0]  s8;
    begin
      s13 = {1'b0, hi, lo[`PRESCALE_BITS-1:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8  = {1'b0, lo} + 9'h001;
      case (m)
        // upper low-byte bits are left as they are
        `MODE_13: begin
          bump = {s13[13], s13[12:5], lo[7:5], s13[4:0]};  // [R7] [R8]
        end
        `MODE_16: begin
          bump = s16;                                      // [R12] [R8]
        end
        `MODE_RELOAD: begin
          bump = s8[8] ? {1'b1, hi, hi}
                       : {1'b0, hi, s8[7:0]};              // [R13]
        end
        default: begin
          bump = {s8[8], hi, s8[7:0]};                     // [R15]
        end
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers, two flops before any logic
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {GATE1_PIN_IN, GATE0_PIN_IN, COUNT1_IN, COUNT0_IN};
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // machine cycle divider, one enable pulse every six clocks
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      phase <= 3'h0;
    end else if (phase == `MC_LAST) begin
      phase <= 3'h0;                                        // [R1]
    end else begin
      phase <= phase + 3'h1;
    end
  end
  assign mc_tick = (phase == `MC_LAST);

  // ==========================================================
  // per timer edge detector and count step select
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : chan
      wire is_counter;
      assign is_counter = (gi == 0) ? func_zero : func_one;
      // sample once per machine cycle; a detected fall is held one
      // machine cycle so the step lands in the following cycle
      always @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
          sample[gi]    <= 1'b0;
          edge_pend[gi] <= 1'b0;
        end else if (mc_tick) begin
          sample[gi]    <= pin_sync[gi];                    // [R2]
          edge_pend[gi] <= sample[gi] & ~pin_sync[gi];      // [R2] [R4]
        end
      end
      assign count_step[gi] = mc_tick &
                              (is_counter ? edge_pend[gi]   // [R3]
                                          : 1'b1);          // [R1]
    end
  endgenerate

  // ==========================================================
  // counter next values and overflow events
  always @* begin
    en_zero = run_bit_zero & (~gate_zero | pin_sync[2]);    // [R9]
    // with timer zero split, timer one ignores its run bit and is started
    // and stopped by its gate and by leaving or entering its own mode 3
    en_one  = (split_zero ? 1'b1 : run_bit_one) &           // [R16]
              (mode_one != `MODE_SPLIT) &                   // [R14]
              (~gate_one | pin_sync[3]);                    // [R9]
    {ovf_zero, next_high_zero, next_low_zero} =
      {1'b0, count_high_byte_zero, count_low_byte_zero};
    if (en_zero & count_step[0]) begin
      {ovf_zero, next_high_zero, next_low_zero} =
        bump(mode_zero, count_low_byte_zero, count_high_byte_zero);
    end
    // split high byte counts machine cycles under run_bit_one
    sum_high = {1'b0, count_high_byte_zero} + 9'h001;
    ovf_zero_high = 1'b0;
    if (split_zero & run_bit_one & mc_tick) begin
      next_high_zero = sum_high[7:0];                       // [R15]
      ovf_zero_high  = sum_high[8];                         // [R15]
    end
    {ovf_one, next_high_one, next_low_one} =
      {1'b0, count_high_byte_one, count_low_byte_one};
    if (en_one & count_step[1]) begin
      {ovf_one, next_high_one, next_low_one} =
        bump(mode_one, count_low_byte_one, count_high_byte_one);
    end
  end

  // timer one loses its flag while the split high byte owns it
  assign set_flag_zero = ovf_zero;                          // [R8]
  assign set_flag_one  = split_zero ? ovf_zero_high         // [R15]
                                    : ovf_one;              // [R8]

  // ==========================================================
  // wishbone decode; a write lands on the edge that sees ack high
  assign bus_req = WB_CYC_IN & WB_STB_IN;
  assign wr_fire = bus_req & WB_WE_IN & WB_ACK_OUT & WB_SEL_IN[0];
  assign wdat    = WB_DAT_IN[7:0];
  assign irq_clear = (wr_fire && WB_ADR_IN == `OFS_IRQ_CLR)
                     ? wdat[1:0] : 2'h0;

  // ==========================================================
  // mode and port configuration registers
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_mode_reg <= `RST_BYTE;
      port_cfg_reg   <= `RST_BYTE;
      irq_enable     <= `RST_IRQ;
    end else if (wr_fire) begin
      if (WB_ADR_IN == `OFS_MODE) begin
        timer_mode_reg <= wdat;                             // [R6] [R11]
      end
      if (WB_ADR_IN == `OFS_PORT_CFG) begin
        port_cfg_reg <= wdat;
      end
      if (WB_ADR_IN == `OFS_IRQ_EN) begin
        irq_enable <= wdat[1:0];
      end
    end
  end

  // ==========================================================
  // control register: run bits and overflow flags
  // a hardware set in the same cycle beats a clear from either side
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_control_reg <= `RST_BYTE;
    end else begin
      if (wr_fire && WB_ADR_IN == `OFS_CTRL) begin
        timer_control_reg[`B_RUN0] <= wdat[`B_RUN0];        // [R10]
        timer_control_reg[`B_RUN1] <= wdat[`B_RUN1];        // [R10]
        timer_control_reg[`B_FLAG0] <= set_flag_zero |
                                       wdat[`B_FLAG0];      // [R19]
        timer_control_reg[`B_FLAG1] <= set_flag_one |
                                       wdat[`B_FLAG1];      // [R19]
      end else begin
        timer_control_reg[`B_FLAG0] <= set_flag_zero |
          (overflow_flag_zero & ~INT_ACK0_IN);              // [R19]
        timer_control_reg[`B_FLAG1] <= set_flag_one |
          (overflow_flag_one & ~INT_ACK1_IN);               // [R19]
      end
    end
  end

  // ==========================================================
  // count bytes; a software write wins over a step in that cycle
  // the run bit never touches these, counting resumes in place
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      count_low_byte_zero  <= `RST_BYTE;
      count_high_byte_zero <= `RST_BYTE;
      count_low_byte_one   <= `RST_BYTE;
      count_high_byte_one  <= `RST_BYTE;
    end else begin
      count_low_byte_zero  <= (wr_fire && WB_ADR_IN == `OFS_CNT0_LO)
                              ? wdat : next_low_zero;       // [R10]
      count_high_byte_zero <= (wr_fire && WB_ADR_IN == `OFS_CNT0_HI)
                              ? wdat : next_high_zero;
      count_low_byte_one   <= (wr_fire && WB_ADR_IN == `OFS_CNT1_LO)
                              ? wdat : next_low_one;
      count_high_byte_one  <= (wr_fire && WB_ADR_IN == `OFS_CNT1_HI)
                              ? wdat : next_high_one;
    end
  end

  // ==========================================================
  // toggle outputs: held at one while disabled, so a fresh enable
  // starts high until the first overflow
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      toggle_level <= {`RST_TOGGLE, `RST_TOGGLE};
    end else begin
      if (!toggle_en_zero) begin
        toggle_level[0] <= `RST_TOGGLE;                     // [R18]
      end else if (ovf_zero) begin
        toggle_level[0] <= ~toggle_level[0];                // [R17]
      end
      if (!toggle_en_one) begin
        toggle_level[1] <= `RST_TOGGLE;                     // [R18]
      end else if (ovf_one) begin
        toggle_level[1] <= ~toggle_level[1];                // [R17]
      end
    end
  end

  // pin drives only while toggling; the count input then sees it
  assign COUNT0_OUT    = toggle_level[0];
  assign COUNT0_OE_OUT = toggle_en_zero;                    // [R17]
  assign COUNT1_OUT    = toggle_level[1];
  assign COUNT1_OE_OUT = toggle_en_one;                     // [R17]

  // ==========================================================
  // sticky interrupt status, set wins over the clear register
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_status <= `RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clear) |
                    {set_flag_one, set_flag_zero};
    end
  end
  assign IRQ_OUT = |(irq_status & irq_enable);

  // ==========================================================
  // flag and baud outputs; the baud pulse stays live even when the
  // split high byte has taken timer one's flag
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      OVF_FLAG_OUT  <= 2'h0;
      BAUD_TICK_OUT <= 1'b0;
    end else begin
      OVF_FLAG_OUT  <= {timer_control_reg[`B_FLAG1],
                        timer_control_reg[`B_FLAG0]};
      BAUD_TICK_OUT <= ovf_one;                             // [R16]
    end
  end

  // ==========================================================
  // read mux; unmapped and write-only offsets read zero
  always @* begin
    case (WB_ADR_IN)
      `OFS_MODE:     rd_data = timer_mode_reg;
      `OFS_CTRL:     rd_data = {timer_control_reg[7:4], 4'h0};
      `OFS_CNT0_LO:  rd_data = count_low_byte_zero;
      `OFS_CNT0_HI:  rd_data = count_high_byte_zero;
      `OFS_CNT1_LO:  rd_data = count_low_byte_one;
      `OFS_CNT1_HI:  rd_data = count_high_byte_one;
      `OFS_PORT_CFG: rd_data = port_cfg_reg;
      `OFS_IRQ_STAT: rd_data = {6'h00, irq_status};
      `OFS_IRQ_EN:   rd_data = {6'h00, irq_enable};
      default:       rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // ack one cycle after the request, dropped the cycle after;
  // read data is caught with the ack so it stays steady
  always @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h00000000;
    end else begin
      WB_ACK_OUT <= bus_req & ~WB_ACK_OUT;
      if (bus_req & ~WB_ACK_OUT) begin
        WB_DAT_OUT <= {24'h000000, rd_data};
      end
    end
  end

endmodule

`default_nettype wire

/* verification/count_pin_source.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// far-side source on one count pin
module count_pin_source (
  input  wire logic clk_in,   // bench clock
  input  wire logic oe_in,    // device drives pin
  input  wire logic dut_in,   // device toggle level
  output wire logic pin_out   // resolved pin level
);
  logic ext = 1'b1;
  // the device wins the wire while its enable is up
  assign pin_out = oe_in ? dut_in : ext;
  // each level held eight clocks, above one machine cycle
  task automatic falls(input int n);
    repeat (n) begin
      ext <= 1'b1;
      repeat (8) @(posedge clk_in);
      ext <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

/* verification/dual_timer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_consts.vh"
// ====================
// port checker for the dual timer
module dual_timer_properties (
  input wire logic        CLK_IN,         // clock
  input wire logic        SYS_RST_IN,     // reset
  input wire logic        WB_CYC_IN,      // cycle
  input wire logic        WB_STB_IN,      // strobe
  input wire logic        WB_WE_IN,       // write
  input wire logic [7:0]  WB_ADR_IN,      // address
  input wire logic [3:0]  WB_SEL_IN,      // lanes
  input wire logic [31:0] WB_DAT_OUT,     // read data
  input wire logic        WB_ACK_OUT,     // ack
  input wire logic        COUNT0_OUT,     // pin 0 level
  input wire logic        COUNT0_OE_OUT,  // pin 0 drive
  input wire logic        COUNT1_OUT,     // pin 1 level
  input wire logic        COUNT1_OE_OUT,  // pin 1 drive
  input wire logic        INT_ACK0_IN,    // flag 0 ack
  input wire logic        INT_ACK1_IN,    // flag 1 ack
  input wire logic [1:0]  OVF_FLAG_OUT,   // flags
  input wire logic        BAUD_TICK_OUT   // timer 1 overflow
);
  // a control write lands at the edge that samples ack
  wire wr_ctrl;
  assign wr_ctrl = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_ACK_OUT
                 & WB_SEL_IN[0] & (WB_ADR_IN == `OFS_CTRL);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ====================
  // steps of a bus cycle and of the overflow spacing
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_quiet;
    !BAUD_TICK_OUT [*5];
  endsequence
  // ====================
  // bus answer
  a_ack_follows_req: assert property (s_req |=> WB_ACK_OUT)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  a_read_upper_zero: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // ====================
  // flags clear only by write or acknowledge
  a_flag0_sticky: assert property (
    OVF_FLAG_OUT[0] && !$past(INT_ACK0_IN) && !$past(wr_ctrl) |=>
    OVF_FLAG_OUT[0]) else $error("flag 0 dropped without a clear");
  a_flag1_sticky: assert property (
    OVF_FLAG_OUT[1] && !$past(INT_ACK1_IN) && !$past(wr_ctrl) |=>
    OVF_FLAG_OUT[1]) else $error("flag 1 dropped without a clear");
  // ====================
  // toggle pins idle high and pin 1 moves only on overflow
  a_pin0_idle_high: assert property (
    !COUNT0_OE_OUT && !$past(COUNT0_OE_OUT) |-> COUNT0_OUT)
    else $error("pin 0 not high while toggle off");
  a_pin1_idle_high: assert property (
    !COUNT1_OE_OUT && !$past(COUNT1_OE_OUT) |-> COUNT1_OUT)
    else $error("pin 1 not high while toggle off");
  a_toggle_on_ovf: assert property (
    COUNT1_OE_OUT && $past(COUNT1_OE_OUT) && COUNT1_OUT != $past(COUNT1_OUT)
    |-> BAUD_TICK_OUT or ##1 BAUD_TICK_OUT)
    else $error("pin 1 toggled with no overflow");
  // overflows at most once per machine cycle of six clocks
  a_ovf_spacing: assert property (BAUD_TICK_OUT |=> s_quiet)
    else $error("timer 1 overflows closer than six clocks");
  a_oe_by_write: assert property (
    COUNT1_OE_OUT != $past(COUNT1_OE_OUT)
    |-> $past(WB_ACK_OUT) && $past(WB_WE_IN))
    else $error("pin 1 drive enable moved without a write");
endmodule

bind dual_timer_counter dual_timer_properties u_props (
  .CLK_IN, .SYS_RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN,
  .WB_SEL_IN, .WB_DAT_OUT, .WB_ACK_OUT, .COUNT0_OUT, .COUNT0_OE_OUT,
  .COUNT1_OUT, .COUNT1_OE_OUT, .INT_ACK0_IN, .INT_ACK1_IN, .OVF_FLAG_OUT,
  .BAUD_TICK_OUT);
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dual_timer_consts.vh"
// ====================
// self-checking bench against a small count model
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        gate0 = 1'b0;
  logic        ack0 = 1'b0;
  logic [7:0]  hi;
  logic [31:0] q;
  wire  [31:0] rdat;
  wire  [1:0]  flg;
  wire         ack, o0, oe0, o1, oe1, p0, p1, baud, irq;
  integer      err_count = 0;
  integer      n_tests = 0;
  integer      seed = 32'hbde2;
  integer      bauds = 0, t, n;
  // clock and overflow tally
  always #10 clk = ~clk;
  always @(posedge clk) if (baud === 1'b1) bauds <= bauds + 1;
  dual_timer_counter u_dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .COUNT0_IN(p0), .COUNT0_OUT(o0),
    .COUNT0_OE_OUT(oe0), .COUNT1_IN(p1), .COUNT1_OUT(o1),
    .COUNT1_OE_OUT(oe1), .GATE0_PIN_IN(gate0), .GATE1_PIN_IN(1'b1),
    .INT_ACK0_IN(ack0), .INT_ACK1_IN(1'b0), .OVF_FLAG_OUT(flg),
    .BAUD_TICK_OUT(baud), .IRQ_OUT(irq));
  count_pin_source u_src0 (.clk_in(clk), .oe_in(oe0), .dut_in(o0),
                           .pin_out(p0));
  count_pin_source u_src1 (.clk_in(clk), .oe_in(oe1), .dut_in(o1),
                           .pin_out(p1));
  // ====================
  // bus cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    integer k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k = k + 1;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) err_count = err_count + 1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wb(a, 1'b0, 8'h00);
    chk(nm, e, q);
  endtask
  // wait for flag 0, flag 1 or baud pulse (2)
  task automatic await(input int w, output integer c);
    c = 0;
    do begin
      @(posedge clk);
      c = c + 1;
    end while ((w == 2 ? baud : flg[w & 1]) !== 1'b1 && c < 3000);
    if (c >= 3000) err_count = err_count + 1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====================
  // hang guard
  initial begin
    #(20 * 30000);
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // every register clear, an unmapped word at 8'h28 too
    for (int a = 0; a <= 40; a += 4) rd("reset_reg", a[7:0], 32'h0);
    chk("pin1_idle", 32'h1, {31'h0, o1});
    chk("irq_idle", 32'h0, {31'h0, irq});
    $display("reset test done");
    // timer 1 auto-reload with a random short period, toggle and irq
    hi = 8'hf0 | 8'($random(seed) & 15);
    wb(`OFS_CNT1_HI, 1'b1, hi);
    wb(`OFS_CNT1_LO, 1'b1, hi);
    wb(`OFS_PORT_CFG, 1'b1, 8'h02);
    wb(`OFS_IRQ_EN, 1'b1, 8'h02);
    wb(`OFS_MODE, 1'b1, 8'h20);
    chk("pin1_on", 32'h1, {31'h0, o1});
    wb(`OFS_CTRL, 1'b1, 8'h40);
    await(2, t);
    chk("pin1_toggle", 32'h0, {31'h0, o1});
    await(2, t);
    chk("reload_period", (256 - hi) * 6, t);
    chk("pin1_toggle", 32'h1, {31'h0, o1});
    chk("irq_on", 32'h1, {31'h0, irq});
    rd("reload_keeps_hi", `OFS_CNT1_HI, {24'h0, hi});
    // mode 3 on timer 1 stops it like a cleared run bit
    wb(`OFS_MODE, 1'b1, 8'h30);
    repeat (2) @(posedge clk);
    n = bauds;
    repeat (120) @(posedge clk);
    chk("t1_mode3_stop", n, bauds);
    rd("ctrl_flag1", `OFS_CTRL, 32'hc0);
    wb(`OFS_IRQ_EN, 1'b1, 8'h00);
    rd("irq_status", `OFS_IRQ_STAT, 32'h2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(`OFS_IRQ_CLR, 1'b1, 8'h02);
    rd("irq_cleared", `OFS_IRQ_STAT, 32'h0);
    wb(`OFS_PORT_CFG, 1'b1, 8'h00);
    $display("reload test done");
    // 13-bit mode: upper low-byte bits stay, prescaler wraps
    wb(`OFS_CNT0_LO, 1'b1, 8'hfe);
    wb(`OFS_CNT0_HI, 1'b1, 8'hff);
    wb(`OFS_CTRL, 1'b1, 8'h10);
    await(0, t);
    wb(`OFS_CTRL, 1'b1, 8'h20);
    rd("m0_low", `OFS_CNT0_LO, 32'he0);
    rd("m0_high", `OFS_CNT0_HI, 32'h0);
    repeat (30) @(posedge clk);
    chk("flag0_holds", 32'h1, {31'h0, flg[0]});
    @(posedge clk);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    repeat (2) @(posedge clk);
    chk("flag0_acked", 32'h0, {31'h0, flg[0]});
    wb(`OFS_CNT0_HI, 1'b1, 8'h12);
    wb(`OFS_CTRL, 1'b1, 8'h10);
    rd("run_keeps_count", `OFS_CNT0_HI, 32'h12);
    $display("13-bit test done");
    // gated edge counting on pin 0
    wb(`OFS_MODE, 1'b1, 8'h3d);
    wb(`OFS_CNT0_LO, 1'b1, 8'h00);
    wb(`OFS_CNT0_HI, 1'b1, 8'h00);
    u_src0.falls(3);
    repeat (20) @(posedge clk);
    rd("gate_blocks", `OFS_CNT0_LO, 32'h0);
    @(posedge clk);
    gate0 <= 1'b1;
    n = 1 + ($random(seed) & 7);
    u_src0.falls(n);
    repeat (20) @(posedge clk);
    rd("edge_count", `OFS_CNT0_LO, n);
    wb(`OFS_CTRL, 1'b1, 8'h00);
    $display("counter test done");
    // split timer 0: high byte borrows run and flag of timer 1
    wb(`OFS_MODE, 1'b1, 8'h23);
    wb(`OFS_CNT0_LO, 1'b1, 8'h40);
    wb(`OFS_CNT0_HI, 1'b1, 8'hfe);
    n = bauds;
    wb(`OFS_CTRL, 1'b1, 8'h40);
    await(1, t);
    rd("split_flag1", `OFS_CTRL, 32'hc0);
    rd("split_low_idle", `OFS_CNT0_LO, 32'h40);
    repeat (120) @(posedge clk);
    chk("split_baud", 32'h1, {31'h0, bauds > n});
    wb(`OFS_MODE, 1'b1, 8'h33);
    repeat (2) @(posedge clk);
    n = bauds;
    repeat (120) @(posedge clk);
    chk("split_t1_stop", n, bauds);
    $display("split test done");
    give_verdict;
  end
endmodule
`default_nettype wire
